//--- rtl/ulfmc_consts.svh
// Constant definitions for the serial channel control block.
`ifndef ULFMC_CONSTS_SVH
`define ULFMC_CONSTS_SVH
`define ULFMC_ADDR_FIFO_SETUP 3'h2
`define ULFMC_ADDR_LINE_FMT 3'h3
`define ULFMC_ADDR_MODEM_CTL 3'h4
`define ULFMC_ADDR_FEATURE 3'h5
`define ULFMC_ADDR_ENHANCED 3'h6
`define ULFMC_ADDR_LEVELS 3'h7
`define ULFMC_ADDR_STATUS 3'h1
`define ULFMC_ADDR_EVENTS 3'h0
`define ULFMC_FS_ENABLE 0
`define ULFMC_FS_DMA 3
`define ULFMC_EF_ENABLE 4
`define ULFMC_LF_STOP 2
`define ULFMC_LF_PAR_EN 3
`define ULFMC_LF_EVEN 4
`define ULFMC_LF_FORCE 5
`define ULFMC_LF_BREAK 6
`define ULFMC_LF_DIV 7
`define ULFMC_MC_DTR 0
`define ULFMC_MC_RTS 1
`define ULFMC_MC_AUX1 2
`define ULFMC_MC_AUX2 3
`define ULFMC_MC_LOOP 4
`define ULFMC_MC_ANY 5
`define ULFMC_MC_IR 6
`define ULFMC_BYTE_ZERO 8'h00
`define ULFMC_TBL_A 2'h0
`define ULFMC_TBL_B 2'h1
`define ULFMC_TBL_C 2'h2
`endif

//--- rtl/ulfmc_pkg.sv
// Types shared by the serial channel control block.
`default_nettype none
package ulfmc_pkg;
    typedef struct packed {
        logic [1:0] word_len;
        logic two_stop;
        logic par_en;
        logic par_bit_valid;
        logic par_even;
        logic par_forced;
        logic par_forced_val;
    } ulfmc_format_type;
    typedef struct packed {
        logic [6:0] rx_level;
        logic [6:0] tx_level;
    } ulfmc_levels_type;
endpackage : ulfmc_pkg
`default_nettype wire

//--- rtl/ulfmc_trigger_table.sv
// Registered lookup of receive and transmit trigger levels.
`timescale 1ns/1ps
`default_nettype none
`include "ulfmc_consts.svh"
module ulfmc_trigger_table (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic [1:0] table_in,
    input wire logic [1:0] rx_code_in,
    input wire logic [1:0] tx_code_in,
    output var ulfmc_pkg::ulfmc_levels_type levels_out
);
    ulfmc_pkg::ulfmc_levels_type levels_next;

    always_comb
    begin
        levels_next.rx_level = 7'h01;
        levels_next.tx_level = 7'h01;
        unique case (table_in)
            `ULFMC_TBL_A:
            begin
                // Table A receive 1, 4, 8, 14; transmit fixed at 1.
                unique case (rx_code_in)
                    2'h0: levels_next.rx_level = 7'h01;
                    2'h1: levels_next.rx_level = 7'h04;
                    2'h2: levels_next.rx_level = 7'h08;
                    2'h3: levels_next.rx_level = 7'h0e;
                endcase
            end
            `ULFMC_TBL_B:
            begin
                unique case (rx_code_in)
                    2'h0: levels_next.rx_level = 7'h08;
                    2'h1: levels_next.rx_level = 7'h10;
                    2'h2: levels_next.rx_level = 7'h18;
                    2'h3: levels_next.rx_level = 7'h1c;
                endcase
                unique case (tx_code_in)
                    2'h0: levels_next.tx_level = 7'h10;
                    2'h1: levels_next.tx_level = 7'h08;
                    2'h2: levels_next.tx_level = 7'h18;
                    2'h3: levels_next.tx_level = 7'h1e;
                endcase
            end
            default:
            begin
                // Table C; the programmable table falls back to it here.
                unique case (rx_code_in)
                    2'h0: levels_next.rx_level = 7'h08;
                    2'h1: levels_next.rx_level = 7'h10;
                    2'h2: levels_next.rx_level = 7'h38;
                    2'h3: levels_next.rx_level = 7'h3c;
                endcase
                unique case (tx_code_in)
                    2'h0: levels_next.tx_level = 7'h08;
                    2'h1: levels_next.tx_level = 7'h10;
                    2'h2: levels_next.tx_level = 7'h20;
                    2'h3: levels_next.tx_level = 7'h38;
                endcase
            end
        endcase
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            levels_out <= '{rx_level: 7'h01, tx_level: 7'h01};
        end
        else if (ce_in)
        begin
            levels_out <= levels_next;
        end
    end
endmodule : ulfmc_trigger_table
`default_nettype wire

//--- rtl/ulfmc_top.sv
// Control registers, trigger logic and line shaping of one serial channel.
//
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ulfmc_consts.svh"
module ulfmc_top (
    input wire logic CLK_SYS_IN,
    input wire logic RST_IN,
    input wire logic CE_IN,
    input wire logic [2:0] ADDR_IN,
    input wire logic [7:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    output logic [7:0] RDATA_OUT,
    input wire logic [6:0] RX_COUNT_IN,
    input wire logic [6:0] TX_COUNT_IN,
    input wire logic TX_RELOAD_IN,
    input wire logic TX_SERIAL_IN,
    input wire logic IR_TX_SERIAL_IN,
    input wire logic RX_CHAR_IN,
    input wire logic RX_IS_FLOW_CHAR_IN,
    input wire logic SW_FLOW_ACTIVE_IN,
    input wire logic AUTO_RTS_ACTIVE_IN,
    input wire logic AUTO_RTS_LEVEL_IN,
    input wire logic RI_PIN_IN,
    input wire logic RX_PIN_IN,
    input wire logic IR_RX_PIN_IN,
    output logic TX_PIN_OUT,
    output logic IR_TX_PIN_OUT,
    output logic RX_DATA_OUT,
    output logic DTR_N_OUT,
    output logic RTS_N_OUT,
    output logic AUX_TWO_N_OUT,
    output logic IRQ_OUT,
    output logic IRQ_OE_N_OUT,
    output logic RX_READY_N_OUT,
    output logic TX_READY_N_OUT,
    output logic TX_IRQ_OUT,
    output logic RX_IRQ_OUT,
    output logic TX_RESUME_OUT,
    output logic RX_STORE_OUT,
    output logic RING_OUT,
    output logic DIV_SELECT_OUT,
    output logic LOOPBACK_OUT,
    output logic IR_MODE_OUT,
    output var ulfmc_pkg::ulfmc_format_type FORMAT_OUT
);
    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [7:0] fifo_setup_reg;
    logic [7:0] line_format_control_reg;
    logic [7:0] modem_output_control_reg;
    logic [7:0] feature_control_reg;
    logic [7:0] enhanced_feature_reg;
    logic [1:0] table_reg;
    logic [1:0] tx_code_reg;
    logic [1:0] rx_code_reg;
    logic tx_filled_reg;
    logic rx_above_reg;
    logic [2:0] ri_sync_reg;
    logic [2:0] rx_sync_reg;
    logic [2:0] irrx_sync_reg;
    logic ri_level_reg;
    logic rx_level_reg;
    logic irrx_level_reg;
    ulfmc_pkg::ulfmc_levels_type levels;
    ulfmc_pkg::ulfmc_format_type format_next;
    logic [7:0] rdata_next;
    logic wr_fifo;
    logic wr_feature;
    logic tx_irq_next;
    logic rx_irq_next;

    assign wr_fifo = WR_IN && (ADDR_IN == `ULFMC_ADDR_FIFO_SETUP);
    assign wr_feature = WR_IN && (ADDR_IN == `ULFMC_ADDR_FEATURE);

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            fifo_setup_reg <= `ULFMC_BYTE_ZERO;
        end
        else if (CE_IN && wr_fifo && WDATA_IN[`ULFMC_FS_ENABLE])
        begin
            // Other bits only take effect when the enable bit rides along.
            fifo_setup_reg <= WDATA_IN;
        end
        else if (CE_IN && wr_fifo)
        begin
            fifo_setup_reg[`ULFMC_FS_ENABLE] <= 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            tx_code_reg <= 2'h0;
            rx_code_reg <= 2'h0;
        end
        else if (CE_IN && wr_fifo && WDATA_IN[`ULFMC_FS_ENABLE])
        begin
            rx_code_reg <= WDATA_IN[7:6];
            if (enhanced_feature_reg[`ULFMC_EF_ENABLE])
            begin
                // Transmit trigger bits are locked unless enhanced mode is on.
                tx_code_reg <= WDATA_IN[5:4];
            end
        end
    end

    always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            feature_control_reg <= `ULFMC_BYTE_ZERO;
            table_reg <= `ULFMC_TBL_A;
        end
        else if (CE_IN && wr_feature)
        begin
            feature_control_reg <= WDATA_IN;
            // One table for both directions; the latest write wins.
            table_reg <= WDATA_IN[5:4];
        end
    end

    always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            enhanced_feature_reg <= `ULFMC_BYTE_ZERO;
            line_format_control_reg <= `ULFMC_BYTE_ZERO;
            modem_output_control_reg <= `ULFMC_BYTE_ZERO;
        end
        else if (CE_IN && WR_IN)
        begin
            if (ADDR_IN == `ULFMC_ADDR_ENHANCED)
            begin
                enhanced_feature_reg <= WDATA_IN;
            end
            if (ADDR_IN == `ULFMC_ADDR_LINE_FMT)
            begin
                line_format_control_reg <= WDATA_IN;
            end
            if (ADDR_IN == `ULFMC_ADDR_MODEM_CTL)
            begin
                modem_output_control_reg <= {1'b0, WDATA_IN[6:0]};
            end
        end
    end

    ulfmc_trigger_table u_table (
        .clk_in(CLK_SYS_IN),
        .rst_in(RST_IN),
        .ce_in(CE_IN),
        .table_in(table_reg),
        .rx_code_in(rx_code_reg),
        .tx_code_in(tx_code_reg),
        .levels_out(levels)
    );

    // ----------------------------------------
    // Register reads
    // ----------------------------------------
    always_comb
    begin
        rdata_next = `ULFMC_BYTE_ZERO;
        unique case (ADDR_IN)
            `ULFMC_ADDR_LINE_FMT: rdata_next = line_format_control_reg;
            `ULFMC_ADDR_MODEM_CTL: rdata_next = modem_output_control_reg;
            `ULFMC_ADDR_FEATURE: rdata_next = feature_control_reg;
            `ULFMC_ADDR_ENHANCED: rdata_next = enhanced_feature_reg;
            `ULFMC_ADDR_LEVELS: rdata_next = {1'b0, levels.rx_level};
            `ULFMC_ADDR_STATUS: rdata_next = {1'b0, levels.tx_level};
            `ULFMC_ADDR_EVENTS: rdata_next = {4'h0, ri_level_reg, tx_filled_reg,
                                              RX_IRQ_OUT, TX_IRQ_OUT};
            default: rdata_next = `ULFMC_BYTE_ZERO;
        endcase
    end

    always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            RDATA_OUT <= `ULFMC_BYTE_ZERO;
        end
        else if (CE_IN)
        begin
            RDATA_OUT <= RD_IN ? rdata_next : `ULFMC_BYTE_ZERO;
        end
    end

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            ri_sync_reg <= 3'h7;
            rx_sync_reg <= 3'h7;
            irrx_sync_reg <= 3'h0;
            ri_level_reg <= 1'b1;
            rx_level_reg <= 1'b1;
            irrx_level_reg <= 1'b0;
        end
        else if (CE_IN)
        begin
            ri_sync_reg <= {ri_sync_reg[1:0], RI_PIN_IN};
            rx_sync_reg <= {rx_sync_reg[1:0], RX_PIN_IN};
            irrx_sync_reg <= {irrx_sync_reg[1:0], IR_RX_PIN_IN};
            if (ri_sync_reg[1] == ri_sync_reg[2])
            begin
                ri_level_reg <= ri_sync_reg[2];
            end
            if (rx_sync_reg[1] == rx_sync_reg[2])
            begin
                rx_level_reg <= rx_sync_reg[2];
            end
            if (irrx_sync_reg[1] == irrx_sync_reg[2])
            begin
                irrx_level_reg <= irrx_sync_reg[2];
            end
        end
    end

    // ----------------------------------------
    // Trigger interrupts and ready pins
    // ----------------------------------------
    always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            tx_filled_reg <= 1'b0;
        end
        else if (CE_IN)
        begin
            if (TX_COUNT_IN > levels.tx_level)
            begin
                tx_filled_reg <= 1'b1;
            end
            else if (TX_RELOAD_IN || TX_COUNT_IN == 7'h00)
            begin
                tx_filled_reg <= 1'b0;
            end
        end
    end

    // Filled above the level: fire below it; otherwise wait for empty.
    assign tx_irq_next = tx_filled_reg ? (TX_COUNT_IN < levels.tx_level)
                                       : (TX_COUNT_IN == 7'h00);
    assign rx_irq_next = (RX_COUNT_IN >= levels.rx_level);

    always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            TX_IRQ_OUT <= 1'b0;
            RX_IRQ_OUT <= 1'b0;
            rx_above_reg <= 1'b0;
            TX_READY_N_OUT <= 1'b0;
            RX_READY_N_OUT <= 1'b1;
            IRQ_OUT <= 1'b0;
        end
        else if (CE_IN)
        begin
            TX_IRQ_OUT <= tx_irq_next;
            RX_IRQ_OUT <= rx_irq_next;
            rx_above_reg <= rx_irq_next;
            IRQ_OUT <= tx_irq_next || rx_irq_next;
            if (fifo_setup_reg[`ULFMC_FS_DMA])
            begin
                // DMA mode: request by trigger level, not by single characters.
                RX_READY_N_OUT <= !rx_irq_next;
                TX_READY_N_OUT <= (TX_COUNT_IN > levels.tx_level) && !tx_irq_next;
            end
            else
            begin
                RX_READY_N_OUT <= (RX_COUNT_IN == 7'h00);
                TX_READY_N_OUT <= (TX_COUNT_IN != 7'h00);
            end
        end
    end

    // ----------------------------------------
    // Character format
    // ----------------------------------------
    always_comb
    begin
        format_next.word_len = line_format_control_reg[1:0];
        format_next.two_stop = line_format_control_reg[`ULFMC_LF_STOP];
        format_next.par_en = line_format_control_reg[`ULFMC_LF_PAR_EN];
        format_next.par_even = line_format_control_reg[`ULFMC_LF_EVEN];
        format_next.par_forced = line_format_control_reg[`ULFMC_LF_FORCE];
        // Forced parity is mark for even-select clear and space for set.
        format_next.par_forced_val = !line_format_control_reg[`ULFMC_LF_EVEN];
        format_next.par_bit_valid = format_next.par_en;
    end

    // ----------------------------------------
    // Line and modem outputs
    // ----------------------------------------
    always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            FORMAT_OUT <= '0;
            DIV_SELECT_OUT <= 1'b0;
            TX_PIN_OUT <= 1'b1;
            IR_TX_PIN_OUT <= 1'b0;
            RX_DATA_OUT <= 1'b1;
            DTR_N_OUT <= 1'b1;
            RTS_N_OUT <= 1'b1;
            AUX_TWO_N_OUT <= 1'b1;
            IRQ_OE_N_OUT <= 1'b1;
            RING_OUT <= 1'b0;
            LOOPBACK_OUT <= 1'b0;
            IR_MODE_OUT <= 1'b0;
            TX_RESUME_OUT <= 1'b0;
            RX_STORE_OUT <= 1'b0;
        end
        else if (CE_IN)
        begin
            FORMAT_OUT <= format_next;
            DIV_SELECT_OUT <= line_format_control_reg[`ULFMC_LF_DIV];
            LOOPBACK_OUT <= modem_output_control_reg[`ULFMC_MC_LOOP];
            IR_MODE_OUT <= modem_output_control_reg[`ULFMC_MC_IR];
            // Loopback keeps the pins idle unless break is set, and feeds transmit straight back.
            if (line_format_control_reg[`ULFMC_LF_BREAK])
            begin
                TX_PIN_OUT <= 1'b0;
                IR_TX_PIN_OUT <= 1'b0;
            end
            else if (modem_output_control_reg[`ULFMC_MC_LOOP])
            begin
                TX_PIN_OUT <= 1'b1;
                IR_TX_PIN_OUT <= 1'b0;
            end
            else if (modem_output_control_reg[`ULFMC_MC_IR])
            begin
                TX_PIN_OUT <= 1'b1;
                IR_TX_PIN_OUT <= IR_TX_SERIAL_IN;
            end
            else
            begin
                TX_PIN_OUT <= TX_SERIAL_IN;
                IR_TX_PIN_OUT <= 1'b0;
            end
            if (modem_output_control_reg[`ULFMC_MC_LOOP])
            begin
                RX_DATA_OUT <= TX_SERIAL_IN;
                RING_OUT <= modem_output_control_reg[`ULFMC_MC_AUX1];
            end
            else
            begin
                RX_DATA_OUT <= modem_output_control_reg[`ULFMC_MC_IR] ? irrx_level_reg
                                                                      : rx_level_reg;
                RING_OUT <= !ri_level_reg;
            end
            DTR_N_OUT <= !modem_output_control_reg[`ULFMC_MC_DTR];
            RTS_N_OUT <= AUTO_RTS_ACTIVE_IN ? AUTO_RTS_LEVEL_IN
                                            : !modem_output_control_reg[`ULFMC_MC_RTS];
            AUX_TWO_N_OUT <= !modem_output_control_reg[`ULFMC_MC_AUX2];
            IRQ_OE_N_OUT <= !modem_output_control_reg[`ULFMC_MC_AUX2];
            // Any character restarts transmit; flow characters stay out of the FIFO.
            TX_RESUME_OUT <= RX_CHAR_IN && modem_output_control_reg[`ULFMC_MC_ANY];
            RX_STORE_OUT <= RX_CHAR_IN && !(modem_output_control_reg[`ULFMC_MC_ANY]
                                            && SW_FLOW_ACTIVE_IN && RX_IS_FLOW_CHAR_IN);
        end
    end
endmodule : ulfmc_top
`default_nettype wire

//--- testbench/ulfmc_monitor.sv
// Port checker of the serial channel control block.
`timescale 1ns/1ps
`default_nettype none
module ulfmc_monitor (
    input wire logic CLK_SYS_IN,
    input wire logic RST_IN,
    input wire logic [2:0] ADDR_IN,
    input wire logic [7:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    input wire logic [7:0] RDATA_OUT,
    input wire logic AUTO_RTS_ACTIVE_IN,
    input wire logic AUTO_RTS_LEVEL_IN,
    input wire logic TX_PIN_OUT,
    input wire logic DTR_N_OUT,
    input wire logic RTS_N_OUT,
    input wire logic AUX_TWO_N_OUT,
    input wire logic IRQ_OE_N_OUT,
    input wire logic DIV_SELECT_OUT,
    input wire logic LOOPBACK_OUT,
    input wire logic IR_MODE_OUT,
    input wire ulfmc_pkg::ulfmc_format_type FORMAT_OUT
);
    default clocking mon_cb @(posedge CLK_SYS_IN);
    endclocking
    default disable iff (RST_IN);
    sequence lcr_wr;
        WR_IN && ADDR_IN == 3'h3;
    endsequence
    sequence mcr_wr;
        WR_IN && ADDR_IN == 3'h4;
    endsequence
    break_low_a:
        assert property (lcr_wr ##0 WDATA_IN[6] |-> ##2 !TX_PIN_OUT)
        else $error("break");
    div_select_a:
        assert property (lcr_wr |-> ##2 DIV_SELECT_OUT == $past(WDATA_IN[7], 2))
        else $error("divisor select");
    word_format_a:
        assert property (lcr_wr |-> ##2 FORMAT_OUT.word_len == $past(WDATA_IN[1:0], 2)
            && FORMAT_OUT.par_en == $past(WDATA_IN[3], 2))
        else $error("format");
    dtr_pin_a:
        assert property (mcr_wr |-> ##2 DTR_N_OUT == !$past(WDATA_IN[0], 2))
        else $error("dtr");
    irq_enable_a:
        assert property (mcr_wr |-> ##2 AUX_TWO_N_OUT == !$past(WDATA_IN[3], 2)
            && IRQ_OE_N_OUT == AUX_TWO_N_OUT)
        else $error("irq enable");
    loop_mode_a:
        assert property (mcr_wr |-> ##2 LOOPBACK_OUT == $past(WDATA_IN[4], 2)
            && IR_MODE_OUT == $past(WDATA_IN[6], 2))
        else $error("modes");
    rts_auto_a:
        assert property ($past(AUTO_RTS_ACTIVE_IN) |-> RTS_N_OUT == $past(AUTO_RTS_LEVEL_IN))
        else $error("auto rts");
    read_idle_a:
        assert property (!$past(RD_IN) |-> RDATA_OUT == 8'h00)
        else $error("read data idle");
endmodule : ulfmc_monitor
bind ulfmc_top ulfmc_monitor u_mon (
    .CLK_SYS_IN(CLK_SYS_IN), .RST_IN(RST_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN),
    .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT),
    .AUTO_RTS_ACTIVE_IN(AUTO_RTS_ACTIVE_IN), .AUTO_RTS_LEVEL_IN(AUTO_RTS_LEVEL_IN),
    .TX_PIN_OUT(TX_PIN_OUT), .DTR_N_OUT(DTR_N_OUT), .RTS_N_OUT(RTS_N_OUT),
    .AUX_TWO_N_OUT(AUX_TWO_N_OUT), .IRQ_OE_N_OUT(IRQ_OE_N_OUT),
    .DIV_SELECT_OUT(DIV_SELECT_OUT), .LOOPBACK_OUT(LOOPBACK_OUT),
    .IR_MODE_OUT(IR_MODE_OUT), .FORMAT_OUT(FORMAT_OUT)
);
`default_nettype wire

//--- testbench/ulfmc_line_partner.sv
// Remote line device model driving the channel's serial inputs.
`timescale 1ns/1ps
`default_nettype none
module ulfmc_line_partner (
    input wire logic clk_in,
    output logic rx_pin_out,
    output logic ring_n_out,
    output logic ir_rx_out
);
    // Lines rest at their idle levels between characters.
    initial
    begin
        rx_pin_out = 1'h1;
        ring_n_out = 1'h1;
        ir_rx_out = 1'h0;
    end
    task automatic send_bit(input logic v);
        @(posedge clk_in);
        rx_pin_out <= v;
    endtask : send_bit
endmodule : ulfmc_line_partner
`default_nettype wire

//--- testbench/uart_line_fifo_modem_control_tb_top.sv
// Self-checking bench of the serial channel control block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) \
    begin \
        checked++; \
        if ((a) !== (e)) \
        begin \
            n_fail++; \
            $display("FAIL t=%0t got=%0h exp=%0h", $time, (a), (e)); \
        end \
    end
module uart_line_fifo_modem_control_tb_top;
    logic clk, rst, ce, wr, rd, rel, tser, irser, rxc, flw, swf, arts, alvl;
    logic txp, irtx, rxd, dtrn, rtsn, aux2n, irqoen, rxrn, txrn, txi, rxi, txres, rxst;
    logic ring, divs, loopb, irm, rxpin, ripin, irrx, irq;
    logic [2:0] adr;
    logic [7:0] wd, d, rdata;
    logic [6:0] rxn, txn;
    ulfmc_pkg::ulfmc_format_type fmt;
    int n_fail = 0;
    int checked = 0;
    int cycles = 0;
    logic [6:0] rxl [12] = '{7'h01, 7'h04, 7'h08, 7'h0e, 7'h08, 7'h10, 7'h18, 7'h1c,
        7'h08, 7'h10, 7'h38, 7'h3c};
    logic [6:0] txl [12] = '{7'h01, 7'h01, 7'h01, 7'h01, 7'h10, 7'h08, 7'h18, 7'h1e,
        7'h08, 7'h10, 7'h20, 7'h38};
    ulfmc_top dut (
        .CLK_SYS_IN(clk), .RST_IN(rst), .CE_IN(ce), .ADDR_IN(adr), .WDATA_IN(wd),
        .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .RX_COUNT_IN(rxn), .TX_COUNT_IN(txn),
        .TX_RELOAD_IN(rel), .TX_SERIAL_IN(tser), .IR_TX_SERIAL_IN(irser), .RX_CHAR_IN(rxc),
        .RX_IS_FLOW_CHAR_IN(flw), .SW_FLOW_ACTIVE_IN(swf), .AUTO_RTS_ACTIVE_IN(arts),
        .AUTO_RTS_LEVEL_IN(alvl), .RI_PIN_IN(ripin), .RX_PIN_IN(rxpin), .IR_RX_PIN_IN(irrx),
        .TX_PIN_OUT(txp), .IR_TX_PIN_OUT(irtx), .RX_DATA_OUT(rxd), .DTR_N_OUT(dtrn),
        .RTS_N_OUT(rtsn), .AUX_TWO_N_OUT(aux2n), .IRQ_OUT(irq), .IRQ_OE_N_OUT(irqoen),
        .RX_READY_N_OUT(rxrn), .TX_READY_N_OUT(txrn), .TX_IRQ_OUT(txi), .RX_IRQ_OUT(rxi),
        .TX_RESUME_OUT(txres), .RX_STORE_OUT(rxst), .RING_OUT(ring), .DIV_SELECT_OUT(divs),
        .LOOPBACK_OUT(loopb), .IR_MODE_OUT(irm), .FORMAT_OUT(fmt)
    );
    ulfmc_line_partner partner (.clk_in(clk), .rx_pin_out(rxpin), .ring_n_out(ripin),
        .ir_rx_out(irrx));
    task automatic summarize();
        if (n_fail == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task automatic bus_wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        adr <= a;
        wd <= v;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
        step(1);
    endtask : bus_wr
    task automatic bus_rd(input logic [2:0] a);
        @(posedge clk);
        adr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1;
        d = rdata;
    endtask : bus_rd
    task automatic counts(input logic [6:0] r, input logic [6:0] t, input logic p);
        @(posedge clk);
        rel <= p;
        @(posedge clk);
        rel <= 1'h0;
        rxn <= r;
        txn <= t;
        step(4);
    endtask : counts
    task automatic char_in(input logic f);
        @(posedge clk);
        rxc <= 1'h1;
        flw <= f;
        @(posedge clk);
        rxc <= 1'h0;
        #1;
    endtask : char_in
    initial
    begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_fail++;
            summarize();
        end
    end
    initial
    begin
        {rst, ce, tser, alvl} = 4'hf;
        {wr, rd, rel, irser, rxc, flw, swf, arts} = 8'h00;
        {adr, wd, rxn, txn} = '0;
        repeat (4) @(posedge clk);
        rst <= 1'h0;
        #1;
        `CHK({dtrn, rtsn, aux2n, irqoen}, 4'hf)
        `CHK({rxrn, txrn, divs, loopb, irm}, 5'h10)
        for (int i = 0; i < 64; i++)
        begin
            bus_wr(3'h3, i[7:0]);
            `CHK(fmt.word_len, i[1:0])
            `CHK(fmt.two_stop, i[2])
            `CHK({fmt.par_en, txp}, {i[3], 1'h1})
            if (i[3] && !i[5])
                `CHK(fmt.par_even, i[4])
            if (i[3] && i[5])
                `CHK({fmt.par_forced, fmt.par_forced_val}, {1'h1, ~i[4]})
            bus_rd(3'h3);
            `CHK(d, i[7:0])
        end
        bus_wr(3'h3, 8'h40);
        step(20);
        `CHK(txp, 1'h0)
        bus_wr(3'h3, 8'h80);
        `CHK({txp, divs}, 2'h3)
        for (int i = 0; i < 128; i++)
        begin
            bus_wr(3'h4, i[7:0]);
            `CHK({dtrn, rtsn}, {~i[0], ~i[1]})
            `CHK({aux2n, irqoen}, {2{~i[3]}})
            `CHK({loopb, irm}, {i[4], i[6]})
            if (i[6])
                `CHK(irtx, 1'h0)
            if (i[4])
                `CHK(ring, i[2])
            bus_rd(3'h4);
            `CHK(d, i[7:0])
        end
        @(posedge clk);
        arts <= 1'h1;
        step(2);
        `CHK(rtsn, 1'h1)
        @(posedge clk);
        arts <= 1'h0;
        bus_wr(3'h6, 8'h10);
        for (int t = 0; t < 3; t++)
            for (int c = 0; c < 4; c++)
            begin
                bus_wr(3'h5, {2'h0, t[1:0], 4'h0});
                bus_wr(3'h2, {c[1:0], c[1:0], 4'h1});
                step(2);
                bus_rd(3'h7);
                `CHK(d, {1'h0, rxl[t * 4 + c]})
                bus_rd(3'h1);
                `CHK(d, {1'h0, txl[t * 4 + c]})
            end
        bus_wr(3'h2, 8'h00);
        step(2);
        bus_rd(3'h7);
        `CHK(d, 8'h3c)
        bus_wr(3'h6, 8'h00);
        bus_wr(3'h2, 8'h11);
        step(2);
        bus_rd(3'h7);
        `CHK(d, 8'h08)
        bus_rd(3'h1);
        `CHK(d, 8'h38)
        bus_wr(3'h5, 8'h00);
        bus_wr(3'h2, 8'h49);
        counts(7'h03, 7'h00, 1'h0);
        `CHK({rxi, rxrn}, 2'h1)
        counts(7'h04, 7'h00, 1'h0);
        `CHK({rxi, rxrn}, 2'h2)
        bus_wr(3'h2, 8'h41);
        counts(7'h03, 7'h00, 1'h0);
        `CHK({rxi, rxrn}, 2'h0)
        bus_wr(3'h6, 8'h10);
        bus_wr(3'h5, 8'h10);
        bus_wr(3'h2, 8'h01);
        counts(7'h03, 7'h14, 1'h1);
        `CHK({txi, txrn, irq}, 3'h2)
        counts(7'h03, 7'h0f, 1'h0);
        `CHK({txi, txrn, irq}, 3'h7)
        counts(7'h03, 7'h0a, 1'h1);
        `CHK({txi, txrn, irq}, 3'h2)
        counts(7'h03, 7'h00, 1'h0);
        `CHK({txi, txrn, irq}, 3'h5)
        bus_rd(3'h0);
        `CHK(d, 8'h09)
        bus_wr(3'h4, 8'h20);
        @(posedge clk);
        swf <= 1'h1;
        char_in(1'h1);
        `CHK({txres, rxst}, 2'h2)
        char_in(1'h0);
        `CHK({txres, rxst}, 2'h3)
        partner.send_bit(1'h0);
        step(6);
        `CHK(rxd, 1'h0)
        partner.send_bit(1'h1);
        step(6);
        `CHK(rxd, 1'h1)
        bus_wr(3'h4, 8'h40);
        @(posedge clk);
        {tser, irser} <= 2'h1;
        step(2);
        `CHK({txp, irtx, rxd}, 3'h6)
        bus_wr(3'h4, 8'h00);
        `CHK({txp, irtx, rxd}, 3'h1)
        summarize();
    end
endmodule : uart_line_fifo_modem_control_tb_top
`default_nettype wire
